// ### design/dphb_bank.sv
// Holding-register bank of the drive parameters, with the software lock.
// Assumes a front end presents one word access per strobe, synchronous
// to clock_i; the motor-control logic reads the decoded outputs.
`timescale 1ns/1ps
`include "dphb_params.svh"

module dphb_bank
  import dphb_pkg::*;
(
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        nrst_i,
  // Holding-register access
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [15:0] wdata_i,
  output logic      [15:0] rdata_o,
  output logic             ack_o,
  output logic             err_o,
  // Terminals
  input  wire logic        soft_lock_terminal_i,
  // Decoded configuration
  output logic [15:0] output_frequency_setting_o,
  output logic        ol_src_analog_o,
  output logic        ol_src_analog_motor2_o,
  output logic        nonstop_on_o,
  output logic        init_clear_trip_o,
  output logic        init_defaults_o,
  output logic [1:0]  init_region_o
);

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  localparam int N = 20;
  localparam logic [15:0] ADDR [N] = '{
    `DPHB_A_OL_DECEL, `DPHB_A_OL_SRC, `DPHB_A_LOCK, `DPHB_A_NS_EN,
    `DPHB_A_NS_START, `DPHB_A_NS_PAUSE, `DPHB_A_NS_DECEL,
    `DPHB_A_QD_WIDTH, `DPHB_A_AM_GAIN, `DPHB_A_START_F,
    `DPHB_A_CARRIER, `DPHB_A_INIT_TYPE, `DPHB_A_INIT_REGION,
    `DPHB_A_PI_DECEL, `DPHB_A_PI_CURRENT, `DPHB_A_PGAIN, `DPHB_A_ITIME,
    `DPHB_A_OL_DECEL2, `DPHB_A_OL_SRC2, `DPHB_A_FREQ_SET};
  // Reset values are the lowest legal value, so the bank never holds
  // an out-of-range word.
  localparam logic [15:0] LO [N] = '{
    `DPHB_OL_DECEL_MIN, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, `DPHB_NS_DECEL_MIN,
    16'h0000, 16'h0000, `DPHB_START_MIN,
    `DPHB_CARRIER_MIN, 16'h0000, 16'h0000,
    `DPHB_PI_DECEL_MIN, `DPHB_PI_CUR_MIN, `DPHB_PGAIN_MIN, 16'h0000,
    `DPHB_OL_DECEL_MIN, 16'h0000, 16'h0000};
  localparam logic [15:0] HI [N] = '{
    `DPHB_OL_DECEL_MAX, `DPHB_CODE1_MAX, `DPHB_LOCK_MAX,
    `DPHB_CODE1_MAX, `DPHB_VOLT_MAX, `DPHB_VOLT_MAX,
    `DPHB_NS_DECEL_MAX, `DPHB_QD_MAX, `DPHB_AM_MAX,
    `DPHB_START_MAX, `DPHB_CARRIER_MAX, `DPHB_CODE2_MAX,
    `DPHB_CODE2_MAX, `DPHB_PI_DECEL_MAX, `DPHB_PI_CUR_MAX,
    `DPHB_PGAIN_MAX, `DPHB_ITIME_MAX, `DPHB_OL_DECEL_MAX,
    `DPHB_CODE1_MAX, `DPHB_FREQ_MAX};
  localparam int LOCK_IX = 2;
  localparam int FREQ_IX = 19;

  logic [15:0] regs_r [N];
  logic [N-1:0] hit;
  logic        in_range;
  logic        locked;
  logic [15:0] lock_code;
  logic [15:0] rd_mux;
  logic        any_hit;

  assign lock_code = regs_r[LOCK_IX];

  // ----------------------------------------------------------------------
  // Decode and lock
  // ----------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_hit
      assign hit[g] = (addr_i == ADDR[g]);
    end
  endgenerate

  always_comb begin
    any_hit  = |hit;
    in_range = 1'b0;
    rd_mux   = 16'h0000;
    for (int i = 0; i < N; i++) begin
      if (hit[i]) begin
        rd_mux = regs_r[i];
        in_range = (wdata_i >= LO[i]) && (wdata_i <= HI[i]);
        if (i == LOCK_IX && wdata_i == `DPHB_LOCK_HIGH) begin
          in_range = 1'b1;
        end
      end
    end
  end

  // The lock register itself is never protected, so software can
  // always leave a lock state.
  always_comb begin
    locked = 1'b0;
    if (!hit[LOCK_IX]) begin
      unique case (lock_code)
        DPHB_LOCK_SFT_ALL:  locked = soft_lock_terminal_i;
        DPHB_LOCK_SFT_FREQ: locked = soft_lock_terminal_i &&
                                     !hit[FREQ_IX];
        DPHB_LOCK_ALL:      locked = 1'b1;
        DPHB_LOCK_FREQ:     locked = !hit[FREQ_IX];
        default:            locked = 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < N; i++) begin
        regs_r[i] <= LO[i];
      end
    end else if (wr_i && any_hit && in_range && !locked) begin
      for (int i = 0; i < N; i++) begin
        if (hit[i]) begin
          regs_r[i] <= wdata_i;
        end
      end
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= 16'h0000;
      ack_o   <= 1'b0;
      err_o   <= 1'b0;
    end else begin
      ack_o <= wr_i | rd_i;
      err_o <= (wr_i && !(any_hit && in_range && !locked)) ||
               (rd_i && !any_hit);
      if (rd_i) begin
        rdata_o <= rd_mux;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Decoded outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      output_frequency_setting_o <= 16'h0000;
      ol_src_analog_o            <= 1'b0;
      ol_src_analog_motor2_o     <= 1'b0;
      nonstop_on_o               <= 1'b0;
      init_clear_trip_o          <= 1'b0;
      init_defaults_o            <= 1'b0;
      init_region_o              <= 2'b00;
    end else begin
      output_frequency_setting_o <= regs_r[FREQ_IX];
      ol_src_analog_o            <= regs_r[1][0];
      ol_src_analog_motor2_o     <= regs_r[18][0];
      nonstop_on_o               <= regs_r[3][0];
      init_clear_trip_o <= (regs_r[11] != 16'h0001);
      init_defaults_o   <= (regs_r[11] != 16'h0000);
      init_region_o     <= regs_r[12][1:0];
    end
  end

endmodule : dphb_bank

// ### design/dphb_params.svh
// Constants of the drive parameter holding bank.
// Assumes a word-wide holding-register port driven by a network front end.
// Contract
// - Hold overload decel rate 1..300, two motors.
// - Motor one level source: 00 stored, 01 analog.
// - Motor two level source: 00 stored, 01 analog.
// - Store pull-in decel rate 1..30000.
// - Store pull-in current level 200..20000.
// - Code 00 locks all but lock when soft-lock.
// - Code 01 also frees output frequency when soft-lock.
// - Code 02 locks all but lock always.
// - Code 03 locks all but lock, frequency always.
// - Accept lock code 10 as high-level access.
// - Nonstop enable: 00 off, 01 on.
// - Store nonstop start voltage 0..10000.
// - Store decel pause level 0..10000.
// - Store nonstop decel time 1..30000.
// - Store quick decel width 0..100.
// - Store regulator gain 2..50, time 0..1500.
// - Store analog monitor gain 0..255.
// - Store start frequency 5..99.
// - Store carrier frequency 20..120.
// - Decode init type 00, 01, 02.
// - Decode init region 00, 01, 02.
`ifndef DPHB_PARAMS_SVH
`define DPHB_PARAMS_SVH

// ----------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------
`define DPHB_A_OL_DECEL     16'h10B7
`define DPHB_A_OL_SRC       16'h10BB
`define DPHB_A_LOCK         16'h10BC
`define DPHB_A_NS_EN        16'h10C9
`define DPHB_A_NS_START     16'h10CA
`define DPHB_A_NS_PAUSE     16'h10CB
`define DPHB_A_NS_DECEL     16'h10CC
`define DPHB_A_QD_WIDTH     16'h10CE
`define DPHB_A_AM_GAIN      16'h10CF
`define DPHB_A_START_F      16'h10D1
`define DPHB_A_CARRIER      16'h10D2
`define DPHB_A_INIT_TYPE    16'h10D3
`define DPHB_A_INIT_REGION  16'h10D4
`define DPHB_A_PI_DECEL     16'h1171
`define DPHB_A_PI_CURRENT   16'h1172
`define DPHB_A_PGAIN        16'h1173
`define DPHB_A_ITIME        16'h1174
`define DPHB_A_OL_DECEL2    16'h152B
`define DPHB_A_OL_SRC2      16'h152C
`define DPHB_A_FREQ_SET     16'h1001

// ----------------------------------------------------------------------
// Ranges and reset values
// ----------------------------------------------------------------------
`define DPHB_OL_DECEL_MIN   16'h0001
`define DPHB_OL_DECEL_MAX   16'h012C
`define DPHB_PI_DECEL_MIN   16'h0001
`define DPHB_PI_DECEL_MAX   16'h7530
`define DPHB_PI_CUR_MIN     16'h00C8
`define DPHB_PI_CUR_MAX     16'h4E20
`define DPHB_VOLT_MAX       16'h2710
`define DPHB_NS_DECEL_MIN   16'h0001
`define DPHB_NS_DECEL_MAX   16'h7530
`define DPHB_QD_MAX         16'h0064
`define DPHB_PGAIN_MIN      16'h0002
`define DPHB_PGAIN_MAX      16'h0032
`define DPHB_ITIME_MAX      16'h05DC
`define DPHB_AM_MAX         16'h00FF
`define DPHB_START_MIN      16'h0005
`define DPHB_START_MAX      16'h0063
`define DPHB_CARRIER_MIN    16'h0014
`define DPHB_CARRIER_MAX    16'h0078
`define DPHB_FREQ_MAX       16'h7FFF
`define DPHB_CODE1_MAX      16'h0001
`define DPHB_CODE2_MAX      16'h0002
`define DPHB_LOCK_HIGH      16'h000A
`define DPHB_LOCK_MAX       16'h0003

`endif

// ### design/dphb_pkg.sv
// Types of the drive parameter holding bank.
// Assumes the constants header is included alongside.
package dphb_pkg;

  typedef enum logic [15:0] {
    DPHB_LOCK_SFT_ALL  = 16'h0000,
    DPHB_LOCK_SFT_FREQ = 16'h0001,
    DPHB_LOCK_ALL      = 16'h0002,
    DPHB_LOCK_FREQ     = 16'h0003,
    DPHB_LOCK_HIGH     = 16'h000A
  } dphb_lock_e;

  typedef logic [15:0] dphb_word_t;

endpackage : dphb_pkg

// ### dv/dphb_bank_asserts.sv
// Checker of the holding bank, bound to its ports.
// Assumes the lock selection resets to code zero.
`timescale 1ns/1ps
module dphb_bank_asserts (
  // Watched ports
  input wire logic        clock_i,
  input wire logic        nrst_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [15:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic [15:0] rdata_o,
  input wire logic        ack_o,
  input wire logic        err_o,
  input wire logic        soft_lock_terminal_i,
  input wire logic        nonstop_on_o
);
  // ------
  // Lock shadow
  // ------
  logic [15:0] lk_r;
  logic        wp;
  logic        nf;
  assign wp = wr_i && addr_i != 16'h10BC;
  assign nf = wp && addr_i != 16'h1001;
  // Lock writes are never blocked by the lock, so a legal code is taken at once.
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) lk_r <= 16'h0000;
    else if (wr_i && addr_i == 16'h10BC &&
             (wdata_i < 16'h0004 || wdata_i == 16'h000A)) lk_r <= wdata_i;
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  sequence s_ns_on;
    wr_i && addr_i == 16'h10C9 && wdata_i == 16'h0001 ##1 ack_o && !err_o;
  endsequence
  property p_ack; wr_i || rd_i |=> ack_o; endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_hold; !rd_i |=> $stable(rdata_o); endproperty
  a_hold: assert property (p_hold) else $error("rdata moved");
  property p_lk0; soft_lock_terminal_i && lk_r == 0 && wp |=> err_o; endproperty
  a_lk0: assert property (p_lk0) else $error("lock 0");
  property p_lk1; soft_lock_terminal_i && lk_r == 1 && nf |=> err_o; endproperty
  a_lk1: assert property (p_lk1) else $error("lock 1");
  property p_lk2; lk_r == 16'h0002 && wp |=> err_o; endproperty
  a_lk2: assert property (p_lk2) else $error("lock 2");
  property p_lk3; lk_r == 16'h0003 && nf |=> err_o; endproperty
  a_lk3: assert property (p_lk3) else $error("lock 3");
  property p_hi; !wp && wr_i && wdata_i == 16'h000A |=> ack_o && !err_o;
  endproperty
  a_hi: assert property (p_hi) else $error("code A refused");
  property p_ns; s_ns_on |=> nonstop_on_o; endproperty
  a_ns: assert property (p_ns) else $error("nonstop off");
endmodule : dphb_bank_asserts
bind dphb_bank dphb_bank_asserts dphb_bank_asserts_inst (.*);

// ### dv/dphb_master.sv
// Network master model: one holding-register access at a time.
// Assumes the bank answers one cycle after it takes a request.
`timescale 1ns/1ps
module dphb_master (
  // Clock
  input  wire logic        clock_i,
  // Answer
  input  wire logic        ack_i,
  input  wire logic        err_i,
  input  wire logic [15:0] rdata_i,
  // Request
  output logic             wr_o    = 1'b0,
  output logic             rd_o    = 1'b0,
  output logic [15:0]      addr_o  = 16'h0000,
  output logic [15:0]      wdata_o = 16'h0000
);
  // Released address and data lines carry the inverse and both strobes drop to zero, so a stale value never passes.
  task automatic xfer(input logic w, input logic [15:0] a, d,
                      output logic e, output logic [15:0] q);
    @(posedge clock_i);
    #1 {wr_o, rd_o, addr_o, wdata_o} = {w, !w, a, d};
    @(posedge clock_i);
    #1 {wr_o, rd_o, addr_o, wdata_o} = {2'b00, ~a, ~d};
    e = ack_i ? err_i : 1'bx;
    q = rdata_i;
  endtask : xfer
endmodule : dphb_master

// ### dv/test_dphb_bank.sv
// Self-checking bench of the drive parameter holding bank.
// Assumes the master model and the checker are compiled first.
`timescale 1ns/1ps
module test_dphb_bank;
  import dphb_pkg::*;
  localparam dphb_word_t A [20] = '{16'h10B7, 16'h10BB, 16'h10BC,
    16'h10C9, 16'h10CA, 16'h10CB, 16'h10CC, 16'h10CE, 16'h10CF, 16'h10D1,
    16'h10D2, 16'h10D3, 16'h10D4, 16'h1171, 16'h1172, 16'h1173, 16'h1174,
    16'h152B, 16'h152C, 16'h1001};
  localparam dphb_word_t LO [20] = '{16'h0001, 0, 0, 0, 0, 0, 16'h0001,
    0, 0, 16'h0005, 16'h0014, 0, 0, 16'h0001, 16'h00C8, 16'h0002, 0,
    16'h0001, 0, 0};
  localparam dphb_word_t HI [20] = '{16'h012C, 16'h0001, 16'h0003,
    16'h0001, 16'h2710, 16'h2710, 16'h7530, 16'h0064, 16'h00FF, 16'h0063,
    16'h0078, 16'h0002, 16'h0002, 16'h7530, 16'h4E20, 16'h0032, 16'h05DC,
    16'h012C, 16'h0001, 16'h7FFF};
  localparam dphb_word_t LK [5] = '{0, 16'h0001, 16'h0002, 16'h0003,
    16'h000A};
  logic clock_i = 1'b0;
  logic nrst_i = 1'b0;
  logic soft_lock_terminal_i = 1'b0;
  logic wr_i, rd_i, ack_o, err_o, e, ol_src_analog_o, ol_src_analog_motor2_o;
  logic nonstop_on_o, init_clear_trip_o, init_defaults_o;
  logic [1:0] init_region_o;
  dphb_word_t addr_i, wdata_i, rdata_o, output_frequency_setting_o, q, v;
  dphb_word_t m [20];
  int err_count = 0;
  int tests_run = 0;
  int cyc = 0;
  int c;
  always #10 clock_i = ~clock_i;
  dphb_master dphb_master_inst (.clock_i, .ack_i(ack_o), .err_i(err_o),
    .rdata_i(rdata_o), .wr_o(wr_i), .rd_o(rd_i), .addr_o(addr_i),
    .wdata_o(wdata_i));
  dphb_bank dphb_bank_inst (.*);
  // ------
  // Checking tasks
  // ------
  task automatic chk(string n, dphb_word_t x, dphb_word_t s);
    tests_run++;
    if (s !== x) begin
      err_count++;
      $display("[ERR] %s exp %h got %h", n, x, s);
    end
  endtask : chk
  function automatic logic ok(int i, dphb_word_t d);
    logic inr;
    inr = i == 2 ? d < 4 || d == 16'h000A : d >= LO[i] && d <= HI[i];
    return inr && (i == 2 || m[2] == 16'h000A || (i == 19 && m[2][0]) ||
                   (m[2] < 2 && !soft_lock_terminal_i));
  endfunction : ok
  task automatic rdk(int i);
    dphb_master_inst.xfer(1'b0, A[i], 16'h0000, e, q);
    chk("read_err", 16'h0000, {15'h0, e});
    chk("rdata", m[i], q);
    chk("freq", m[19], output_frequency_setting_o);
    chk("decoded", {9'h0, m[1][0], m[18][0], m[3][0], m[11] != 1,
      m[11] != 0, m[12][1:0]}, {9'h0, ol_src_analog_o, ol_src_analog_motor2_o,
      nonstop_on_o, init_clear_trip_o, init_defaults_o, init_region_o});
  endtask : rdk
  task automatic wrk(int i, dphb_word_t d);
    logic a;
    a = ok(i, d);
    dphb_master_inst.xfer(1'b1, A[i], d, e, q);
    chk("write_err", {15'h0, !a}, {15'h0, e});
    if (a) m[i] = d;
    rdk(i);
  endtask : wrk
  task automatic end_of_test();
    $display("Checks %0d, errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_of_test
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      end_of_test();
    end
  end
  initial begin
    void'($urandom(32'h2127));
    repeat (10) @(posedge clock_i);
    #1 nrst_i = 1'b1;
    foreach (m[i]) m[i] = LO[i];
    foreach (m[i]) rdk(i);
    dphb_master_inst.xfer(1'b1, 16'h10B8, 16'h0001, e, q);
    chk("unmapped", 16'h0001, {15'h0, e});
    dphb_master_inst.xfer(1'b0, 16'h10B8, 16'h0000, e, q);
    chk("unmapped_rd_err", 16'h0001, {15'h0, e});
    chk("unmapped_rdata", 16'h0000, q);
    for (c = 0; c < 10; c++) begin
      soft_lock_terminal_i = c[0];
      wrk(2, LK[c / 2]);
      wrk(9, 16'h0007);
      wrk(19, dphb_word_t'(c + 1));
    end
    repeat (400) begin
      c = $urandom_range(19);
      case ($urandom_range(4))
        0: v = LO[c];
        1: v = HI[c];
        2: v = HI[c] + 16'h0001;
        3: v = LO[c] - 16'h0001;
        default: v = dphb_word_t'($urandom_range(HI[c]));
      endcase
      soft_lock_terminal_i = 1'($urandom_range(1));
      wrk(c, v);
    end
    soft_lock_terminal_i = 1'b0;
    wrk(2, 16'h000A);
    wrk(3, 16'h0001);
    wrk(11, 16'h0001);
    wrk(12, 16'h0002);
    end_of_test();
  end
endmodule : test_dphb_bank
